// ---- rtl/adc_conversion_cal_sequencer.sv ----
`default_nettype none
module adc_conversion_cal_sequencer
   import adc_seq_pkg::*;
(
   // System clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_ce,
   // Master clock (link domain)
   input  wire logic        i_master_clock_in,
   // Host pins
   input  wire logic        i_conversion_start_n,
   input  wire logic        i_frame_select_n,
   input  wire logic        i_sclk,
   input  wire logic        i_sdin,
   // Control
   input  wire logic        i_cal_req,
   input  wire logic [1:0]  i_cal_kind,
   input  wire logic        i_power_mode_sel_hi,
   input  wire logic        i_power_mode_sel_lo,
   input  wire logic        i_sdin_drive_req,
   input  wire logic        i_sdin_out_bit,
   input  wire logic        i_sdout_bit,
   // Outputs
   output logic             o_busy,
   output logic             o_sdout,
   output logic             o_sdout_oe,
   output logic             o_sdin_out,
   output logic             o_sdin_oe,
   output logic             o_sdin_rx,
   output logic             o_full_power_down,
   output logic             o_partial_power_down
);
   // Pin synchronisers, system domain
   logic [1:0] cs_s_q, fs_s_q, sclk_s_q, din_s_q, cal_s_q;
   logic       cs_q, sclk_q;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cs_s_q   <= 2'h3;
         fs_s_q   <= 2'h3;
         sclk_s_q <= 2'h0;
         din_s_q  <= 2'h0;
         cal_s_q  <= 2'h0;
         cs_q     <= 1'b1;
         sclk_q   <= 1'b0;
      end else if (i_ce) begin
         cs_s_q   <= {cs_s_q[0], i_conversion_start_n};
         fs_s_q   <= {fs_s_q[0], i_frame_select_n};
         sclk_s_q <= {sclk_s_q[0], i_sclk};
         din_s_q  <= {din_s_q[0], i_sdin};
         cal_s_q  <= {cal_s_q[0], i_cal_req};
         cs_q     <= cs_s_q[1];
         sclk_q   <= sclk_s_q[1];
      end
   end

   logic cs_fall, sclk_rise;
   assign cs_fall   = cs_q && !cs_s_q[1];
   assign sclk_rise = !sclk_q && sclk_s_q[1];

   // Power mode decode
   pwr_mode_t pwr_mode;
   assign pwr_mode = pwr_mode_t'({i_power_mode_sel_hi, i_power_mode_sel_lo});

   logic full_pd_q, part_pd_q;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         full_pd_q <= 1'b0;
         part_pd_q <= 1'b0;
      end else if (i_ce) begin
         full_pd_q <= (pwr_mode == PWR_FULL_DOWN);    // [RULE11]
         part_pd_q <= (pwr_mode == PWR_PARTIAL_DOWN); // [RULE11]
      end
   end
   assign o_full_power_down    = full_pd_q;
   assign o_partial_power_down = part_pd_q;

   // Calibration armed: next start falling edge launches it when idle, or disarms it unlaunched when busy
   logic      cal_arm_q;
   cal_kind_t cal_kind_q;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cal_arm_q  <= 1'b0;
         cal_kind_q <= CAL_NONE;
      end else if (i_ce) begin
         if (cal_s_q[1] && !cal_arm_q) begin
            cal_arm_q  <= 1'b1;
            cal_kind_q <= cal_kind_t'(i_cal_kind);
         end else if (cs_fall) begin
            cal_arm_q <= 1'b0;
         end
      end
   end

   // Start request: toggle into master clock domain, length held stable
   logic [CNT_W-1:0] len_q;
   logic             req_tgl_q, busy_pend_q;
   logic [2:0]       busy_s_q;

   function automatic logic [CNT_W-1:0] seq_len(input logic arm, input cal_kind_t k);
      logic [CNT_W-1:0] r;
      r = CNT_W'(CONV_MCLK); // [RULE1]
      if (arm) begin
         unique case (k)
            CAL_FULL:   r = CNT_W'(CAL_FULL_MCLK);   // [RULE2]
            CAL_DAC_FS: r = CNT_W'(CAL_DAC_FS_MCLK); // [RULE3]
            CAL_OFFSET: r = CNT_W'(CAL_OFFSET_MCLK); // [RULE4]
            CAL_NONE:   r = CNT_W'(CONV_MCLK);
         endcase
      end
      return r;
   endfunction

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         len_q       <= CNT_W'(CONV_MCLK);
         req_tgl_q   <= 1'b0;
         busy_pend_q <= 1'b0;
      end else if (i_ce) begin
         if (cs_fall && !busy_pend_q && !busy_s_q[1]) begin
            len_q       <= seq_len(cal_arm_q, cal_kind_q);
            req_tgl_q   <= ~req_tgl_q;
            busy_pend_q <= 1'b1; // [RULE5]
         end else if (busy_s_q[1] && !busy_s_q[2]) begin
            busy_pend_q <= 1'b0;
         end
      end
   end

   // Master clock domain
   logic [2:0] req_m_q;
   always_ff @(posedge i_master_clock_in or negedge i_nrst) begin
      if (!i_nrst) begin
         req_m_q <= 3'h0;
      end else begin
         req_m_q <= {req_m_q[1:0], req_tgl_q};
      end
   end

   logic busy_m;
   mclk_seq_counter #(
      .W (CNT_W)
   ) u_seq (
      .i_mclk  (i_master_clock_in),
      .i_nrst  (i_nrst),
      .i_start (req_m_q[2] ^ req_m_q[1]),
      .i_len   (len_q),
      .o_busy  (busy_m)
   );

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy_s_q <= 3'h0;
      end else if (i_ce) begin
         busy_s_q <= {busy_s_q[1:0], busy_m};
      end
   end
   // Busy shown from start edge until sequence end
   assign o_busy = busy_pend_q || busy_s_q[1]; // [RULE12]

   // Serial output enable follows frame select
   logic sdout_q, sdout_oe_q;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sdout_q    <= 1'b0;
         sdout_oe_q <= 1'b0;
      end else if (i_ce) begin
         sdout_oe_q <= !fs_s_q[1]; // [RULE7] [RULE8]
         sdout_q    <= i_sdout_bit;
      end
   end
   assign o_sdout    = sdout_q;
   assign o_sdout_oe = sdout_oe_q;

   // Data-in pin turnaround
   logic sdin_oe_q, sdin_out_q;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sdin_oe_q  <= 1'b0;
         sdin_out_q <= 1'b0;
      end else if (i_ce) begin
         sdin_out_q <= i_sdin_out_bit;
         if (fs_s_q[1] || (sclk_rise && !i_sdin_drive_req)) begin
            sdin_oe_q <= 1'b0; // [RULE9]
         end else if (sclk_rise && i_sdin_drive_req) begin
            sdin_oe_q <= 1'b1;
         end
      end
   end
   assign o_sdin_out = sdin_out_q;
   assign o_sdin_oe  = sdin_oe_q;
   assign o_sdin_rx  = din_s_q[1];

   chk_busy_after_start: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // [RULE5]
      i_ce && cs_fall && !o_busy |=> o_busy)
      else $error("busy not raised after start");
   chk_sdout_release: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // [RULE8]
      i_ce && fs_s_q[1] |=> !o_sdout_oe)
      else $error("data out not released");
   chk_sdout_enable: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // [RULE7]
      i_ce && !fs_s_q[1] |=> o_sdout_oe)
      else $error("data out not enabled");
   chk_sdin_turn: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // [RULE9]
      i_ce && sclk_rise && !i_sdin_drive_req |=> !o_sdin_oe)
      else $error("data in not turned to input");
   chk_pwr_full: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // [RULE11]
      i_ce && i_power_mode_sel_hi && !i_power_mode_sel_lo |=> o_full_power_down && !o_partial_power_down)
      else $error("full power down decode wrong");
   chk_pwr_part: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // [RULE11]
      i_ce && i_power_mode_sel_hi && i_power_mode_sel_lo |=> o_partial_power_down && !o_full_power_down)
      else $error("partial power down decode wrong");
   chk_busy_holds: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // [RULE12]
      $fell(busy_s_q[1]) |-> !o_busy)
      else $error("busy stuck after sequence end");
   chk_cal_len: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // [RULE2]
      i_ce && cs_fall && !o_busy && cal_arm_q && cal_kind_q == CAL_FULL |=> len_q == CNT_W'(CAL_FULL_MCLK))
      else $error("full calibration length wrong");
   chk_offset_cal_len: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // [RULE4]
      i_ce && cs_fall && !o_busy && cal_arm_q && cal_kind_q == CAL_OFFSET |=> len_q == CNT_W'(CAL_OFFSET_MCLK))
      else $error("offset calibration length wrong");

   cov_conv:  cover property (@(posedge i_sys_clk) $fell(o_busy) && !cal_arm_q);
   cov_cal:   cover property (@(posedge i_sys_clk) cs_fall && cal_arm_q);
   cov_frame: cover property (@(posedge i_sys_clk) $rose(o_sdout_oe));
   cov_turn:  cover property (@(posedge i_sys_clk) $fell(o_sdin_oe));
endmodule // adc_conversion_cal_sequencer
`default_nettype wire

// ---- rtl/adc_seq_pkg.sv ----
// Function
// RULE1: Conversion lasts exactly 18 master clock periods.
// RULE2: Full self-calibration lasts 125013 master periods.
// RULE3: DAC plus full-scale calibration lasts 111114 periods.
// RULE4: System offset calibration lasts 13899 periods.
// RULE5: Calibration busy rises within 2.5 master periods.
// RULE6: Host holds conversion start low 100 ns.
// RULE7: Data out driven within 50/90 ns of frame.
// RULE8: Data out released within 50 ns of frame end.
// RULE9: Data-in pin turned back to input after clock.
// RULE10: Host waits 400 ns after busy falls.
// RULE11: Power mode 1,0 full down, 1,1 partial.
// RULE12: Busy high for whole sequence, falls at end.
`default_nettype none
package adc_seq_pkg;
   localparam int unsigned SYS_CLK_MHZ       = 25;
   localparam int unsigned SYS_PERIOD_NS     = 40;
   localparam int unsigned CONV_MCLK         = 18;
   localparam int unsigned CAL_FULL_MCLK     = 125013;
   localparam int unsigned CAL_DAC_FS_MCLK   = 111114;
   localparam int unsigned CAL_OFFSET_MCLK   = 13899;
   localparam int unsigned CONVERSION_START_N_MIN_NS     = 100;
   localparam int unsigned CONVERSION_START_N_MIN_CYC    = (CONVERSION_START_N_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int unsigned ACQ_MIN_NS        = 400;
   localparam int unsigned DOUT_EN_MAX_NS    = 50;
   localparam int unsigned DOUT_REL_MAX_NS   = 50;
   localparam int unsigned DOUT_REL_MAX_CYC  = DOUT_REL_MAX_NS / SYS_PERIOD_NS;
   localparam int unsigned CNT_W             = 17;
   typedef enum logic [1:0] {
      CAL_FULL,
      CAL_DAC_FS,
      CAL_OFFSET,
      CAL_NONE
   } cal_kind_t;
   typedef enum logic [1:0] {
      PWR_NORMAL,
      PWR_AUTO,
      PWR_FULL_DOWN,
      PWR_PARTIAL_DOWN
   } pwr_mode_t;
endpackage
`default_nettype wire

// ---- rtl/mclk_seq_counter.sv ----
`default_nettype none
// Link-domain sequencer: counts master clock periods of one sequence
module mclk_seq_counter
   import adc_seq_pkg::*;
#(
   parameter int unsigned W = CNT_W
) (
   // Link clock
   input  wire logic         i_mclk,
   input  wire logic         i_nrst,
   // Control
   input  wire logic         i_start,
   input  wire logic [W-1:0] i_len,
   // Status
   output logic              o_busy
);
   logic [W-1:0] cnt_q;
   logic         busy_q;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
      end else if (i_start && !busy_q) begin
         cnt_q  <= i_len - W'(1);
         busy_q <= 1'b1;
      end else if (busy_q) begin
         if (cnt_q == '0) begin
            busy_q <= 1'b0; // [RULE12]
         end else begin
            cnt_q <= cnt_q - W'(1); // [RULE1] [RULE2] [RULE3] [RULE4]
         end
      end
   end
   assign o_busy = busy_q;

   chk_busy_len_min: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE1]
      $rose(busy_q) && cnt_q == W'(CONV_MCLK - 1) |-> busy_q [*8] ##10 busy_q ##1 !busy_q)
      else $error("conversion busy length wrong");
   chk_busy_cnt_dec: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE12]
      busy_q && $past(busy_q) && cnt_q != '0 |-> ##1 busy_q)
      else $error("busy fell before count end");
   chk_busy_end_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RULE2]
      $fell(busy_q) |-> $past(cnt_q) == '0)
      else $error("busy fell with count left");
endmodule // mclk_seq_counter
`default_nettype wire

// ---- testbench/host_model.sv ----
`default_nettype none
module host_model
   import adc_seq_pkg::*;
(
   // Clock and status
   input  wire logic i_sys_clk,
   input  wire logic i_busy,
   // Host pins
   output logic      o_conversion_start_n,
   output logic      o_frame_select_n,
   output logic      o_sclk,
   output logic      o_sdin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_conversion_start_n = 1'b1;
      o_frame_select_n     = 1'b1;
      o_sclk               = 1'b0;
      o_sdin               = 1'b0;
   end
   // Host never contends on data-in; released line toggles
   always @(posedge i_sys_clk) o_sdin <= ~o_sdin;
   task automatic start_pulse();
      @(posedge i_sys_clk) o_conversion_start_n <= 1'b0;
      repeat (CONVERSION_START_N_MIN_CYC) @(posedge i_sys_clk);
      o_conversion_start_n <= 1'b1;
   endtask
   task automatic settle();
      while (i_busy !== 1'b0) @(posedge i_sys_clk);
      repeat (ACQ_MIN_NS / SYS_PERIOD_NS) @(posedge i_sys_clk);
   endtask
   task automatic frame(input logic lvl);
      @(posedge i_sys_clk) o_frame_select_n <= lvl;
   endtask
   task automatic sclk_edge(input logic lvl);
      @(posedge i_sys_clk) o_sclk <= lvl;
   endtask
endmodule // host_model
`default_nettype wire

// ---- testbench/tb.sv ----
`default_nettype none
module tb
   import adc_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MCLK_NS = 32;
   logic       i_sys_clk, i_nrst, i_master_clock_in, i_cal_req, i_sdin_drive_req, i_sdin_out_bit, i_sdout_bit;
   logic       i_power_mode_sel_hi, i_power_mode_sel_lo, cs_n, fs_n, sclk, host_sdin, sdin_pin, i_ce;
   logic       o_sdin_rx;
   logic       o_busy, o_sdout, o_sdout_oe, o_sdin_out, o_sdin_oe, o_full_power_down, o_partial_power_down;
   logic [1:0] i_cal_kind;
   logic [2:0] mon;
   int         errors = 0;
   int         tests_run = 0;
   assign sdin_pin = o_sdin_oe ? o_sdin_out : host_sdin;
   assign mon = {o_sdin_oe, o_sdout_oe, o_busy};
   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      i_master_clock_in = 1'b0;
      #7;
      forever #16 i_master_clock_in = ~i_master_clock_in;
   end
   adc_conversion_cal_sequencer uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce),
      .i_master_clock_in(i_master_clock_in), .i_conversion_start_n(cs_n), .i_frame_select_n(fs_n),
      .i_sclk(sclk), .i_sdin(sdin_pin), .i_cal_req(i_cal_req), .i_cal_kind(i_cal_kind),
      .i_power_mode_sel_hi(i_power_mode_sel_hi), .i_power_mode_sel_lo(i_power_mode_sel_lo),
      .i_sdin_drive_req(i_sdin_drive_req), .i_sdin_out_bit(i_sdin_out_bit), .i_sdout_bit(i_sdout_bit),
      .o_busy(o_busy), .o_sdout(o_sdout), .o_sdout_oe(o_sdout_oe), .o_sdin_out(o_sdin_out),
      .o_sdin_oe(o_sdin_oe), .o_sdin_rx(o_sdin_rx), .o_full_power_down(o_full_power_down),
      .o_partial_power_down(o_partial_power_down));
   host_model host (.i_sys_clk(i_sys_clk), .i_busy(o_busy), .o_conversion_start_n(cs_n),
      .o_frame_select_n(fs_n), .o_sclk(sclk), .o_sdin(host_sdin));
   task automatic check(input logic seen, input logic exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %b want %b", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge i_sys_clk);
      #1;
   endtask
   task automatic await(input int idx, input logic v, input int lim);
      int i;
      i = 0;
      while (mon[idx] !== v && i < lim) begin
         tick();
         i++;
      end
      check(mon[idx], v);
   endtask
   // Cycles to busy rise, then cycles busy stays high
   task automatic measure(input int n_mclk, input logic refuse);
      int rise;
      int len;
      int lo;
      rise = 0;
      len = 0;
      lo = n_mclk * MCLK_NS / SYS_PERIOD_NS;
      fork
         host.start_pulse();
         while (o_busy !== 1'b1 && rise < 20) begin
            tick();
            rise++;
         end
      join
      if (refuse) host.start_pulse();
      while (o_busy === 1'b1 && len < 20000) begin
         tick();
         len++;
      end
      check(rise <= 6, 1'b1);
      check(len >= lo - 5 && len <= lo + 6, 1'b1);
      host.settle();
   endtask
   task automatic test_conversion();
      measure(CONV_MCLK, 1'b1);
   endtask
   task automatic arm_cal(input logic [1:0] kind);
      @(posedge i_sys_clk) i_cal_kind <= kind;
      @(posedge i_sys_clk) i_cal_req <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      i_cal_req <= 1'b0;
   endtask
   task automatic test_cal_offset();
      arm_cal(2'h2);
      measure(CAL_OFFSET_MCLK, 1'b0);
   endtask
   // Armed kind none still runs a plain conversion
   task automatic test_cal_none();
      arm_cal(2'h3);
      measure(CONV_MCLK, 1'b0);
   endtask
   // Frame select ignored while clock enable is low
   task automatic test_ce();
      @(posedge i_sys_clk) i_ce <= 1'b0;
      host.frame(1'b0);
      repeat (6) tick();
      check(o_sdout_oe, 1'b0);
      @(posedge i_sys_clk) i_ce <= 1'b1;
      await(1, 1'b1, 5);
      host.frame(1'b1);
      await(1, 1'b0, 5);
   endtask
   task automatic test_frame();
      @(posedge i_sys_clk) i_sdout_bit <= 1'b1;
      host.frame(1'b0);
      await(1, 1'b1, 4);
      repeat (2) tick();
      check(o_sdout, 1'b1);
      @(posedge i_sys_clk) i_sdin_drive_req <= 1'b1;
      i_sdin_out_bit <= 1'b1;
      host.sclk_edge(1'b1);
      await(2, 1'b1, 5);
      check(o_sdin_out, 1'b1);
      repeat (3) tick();
      check(o_sdin_rx, 1'b1);
      host.sclk_edge(1'b0);
      @(posedge i_sys_clk) i_sdin_drive_req <= 1'b0;
      host.sclk_edge(1'b1);
      await(2, 1'b0, 5);
      host.sclk_edge(1'b0);
      host.frame(1'b1);
      await(1, 1'b0, 4);
   endtask
   task automatic test_power();
      for (int m = 0; m < 4; m++) begin
         @(posedge i_sys_clk) {i_power_mode_sel_hi, i_power_mode_sel_lo} <= 2'(m);
         repeat (3) tick();
         check(o_full_power_down, m == 2);
         check(o_partial_power_down, m == 3);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #2_000_000;
      errors++;
      complete_run();
   end
   initial begin
      {i_nrst, i_cal_req, i_sdin_drive_req, i_sdin_out_bit, i_sdout_bit} = 5'h0;
      {i_power_mode_sel_hi, i_power_mode_sel_lo, i_cal_kind} = 4'h3;
      i_ce = 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      i_power_mode_sel_lo <= 1'b0;
      i_power_mode_sel_hi <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      test_conversion();
      test_cal_offset();
      test_conversion();
      test_cal_none();
      test_frame();
      test_ce();
      test_power();
      complete_run();
   end
endmodule // tb
`default_nettype wire
